// >>> bench/pcp_board.sv
// board model: resolves each port two pin from all its drivers
`timescale 1ns/1ps
module pcp_board (
  input  wire logic       clock,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_on,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output      logic [7:0] pin_lvl
);
  logic [7:0] flt_r = 8'h55;

  // undriven pin without pull-up wanders every cycle
  always @(posedge clock) begin
    flt_r <= ~flt_r;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_lvl[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_lvl[i] = ext_val[i];
      end else if (pullup_on[i]) begin
        pin_lvl[i] = 1'b1;
      end else begin
        pin_lvl[i] = flt_r[i];
      end
    end
  end
endmodule

// >>> bench/test_pcp_port_two.sv
// self-checking bench for the port two pin control block
`timescale 1ns/1ps
module test_pcp_port_two;
  logic                  clock;
  logic                  reset_n;
  pcp_pkg::pcp_axi_req_t req;
  pcp_pkg::pcp_axi_rsp_t rsp;
  pcp_pkg::pcp_sel_t     sel;
  logic [7:0]            pin_lvl, pin_out, pin_oe, pullup_on, ext_val, ext_en;
  logic                  sck_o, sdo_o, utx, twc_o, twd_o;
  logic                  sck_i, sdi, urx, twc_i, twd_i;
  logic [13:0]           ix [4];
  logic [7:0]            msk [4];
  int                    err_total;
  int                    num_checks;

  pcp_port_two pcp_port_two_i (.clock(clock), .reset_n(reset_n),
    .axi_req(req), .axi_rsp(rsp), .pin_in(pin_lvl), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_on(pullup_on), .route_sel(sel),
    .serial_clock_out(sck_o), .serial_data_out(sdo_o),
    .uart_transmit_line(utx), .twowire_clock_out(twc_o),
    .twowire_data_out(twd_o), .serial_clock_line(sck_i),
    .serial_data_in(sdi), .uart_receive_line(urx),
    .twowire_clock_line(twc_i), .twowire_data_line(twd_i));

  pcp_board pcp_board_i (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_on(pullup_on), .ext_val(ext_val), .ext_en(ext_en),
    .pin_lvl(pin_lvl));

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic conclude();
    if (err_total == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang(input int n);
    if (n >= 50) begin
      err_total++;
      $display("[FAIL] %0t no answer from register bus", $time);
      conclude();
    end
  endtask

  task automatic wr(input logic [13:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    req.awvalid <= 1'b1;
    req.awaddr  <= {a, 2'h0};
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h000000, d};
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid && n < 50);
    hang(n);
    chk(8'(rsp.bresp), 8'(er));
  endtask

  task automatic rd(input logic [13:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    req.arvalid <= 1'b1;
    req.araddr  <= {a, 2'h0};
    req.rready  <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid && n < 50);
    hang(n);
    chk(rsp.rdata[7:0], d);
    chk(8'(rsp.rresp), 8'(er));
  endtask

  task automatic settle();
    repeat (5) @(posedge clock);
  endtask

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    req = '0;
    sel = pcp_pkg::PCP_SEL_UART_A;
    {sck_o, sdo_o, utx, twc_o, twd_o} = 5'h00;
    ext_val = 8'hA5;
    ext_en = 8'hFF;
    err_total = 0;
    num_checks = 0;
    ix = '{pcp_pkg::IDX_DIR, pcp_pkg::IDX_PU, pcp_pkg::IDX_FC,
           pcp_pkg::IDX_OT};
    msk = '{8'hFF, 8'hE7, 8'h3F, 8'hE7};
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    chk(pin_oe, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd(ix[i], 8'h00, pcp_pkg::RESP_OKAY);
      wr(ix[i], 8'hFF, pcp_pkg::RESP_OKAY);
      rd(ix[i], msk[i], pcp_pkg::RESP_OKAY);
      wr(ix[i], 8'h00, pcp_pkg::RESP_OKAY);
    end
    wr(14'h0100, 8'hFF, pcp_pkg::RESP_SLVERR);
    rd(14'h0100, 8'h00, pcp_pkg::RESP_SLVERR);
    // input mode: readback shows pins whatever the output type
    wr(pcp_pkg::IDX_OT, 8'hFF, pcp_pkg::RESP_OKAY);
    wr(pcp_pkg::IDX_PU, 8'hFF, pcp_pkg::RESP_OKAY);
    settle();
    rd(pcp_pkg::IDX_PRD, 8'hA5, pcp_pkg::RESP_OKAY);
    chk(pullup_on, 8'hE7);
    // push-pull output: gated bits read 0, pull-ups off
    ext_en <= 8'h00;
    wr(pcp_pkg::IDX_OT, 8'h00, pcp_pkg::RESP_OKAY);
    wr(pcp_pkg::IDX_DIR, 8'hFF, pcp_pkg::RESP_OKAY);
    wr(pcp_pkg::IDX_LATCH, 8'h5A, pcp_pkg::RESP_OKAY);
    settle();
    chk(pin_oe, 8'hFF);
    chk(pin_out, 8'h5A);
    chk(pullup_on, 8'h00);
    rd(pcp_pkg::IDX_PRD, 8'h18, pcp_pkg::RESP_OKAY);
    rd(pcp_pkg::IDX_LATCH, 8'h5A, pcp_pkg::RESP_OKAY);
    // open drain: high bits other than pins three and four released and pulled up
    wr(pcp_pkg::IDX_OT, 8'hFF, pcp_pkg::RESP_OKAY);
    settle();
    chk(pin_oe, 8'hBD);
    chk(pin_out & 8'h18, 8'h18);
    chk(pullup_on, 8'hE7);
    rd(pcp_pkg::IDX_PRD, 8'h5A, pcp_pkg::RESP_OKAY);
    // peripheral output on pin 0
    wr(pcp_pkg::IDX_OT, 8'h00, pcp_pkg::RESP_OKAY);
    wr(pcp_pkg::IDX_LATCH, 8'h00, pcp_pkg::RESP_OKAY);
    wr(pcp_pkg::IDX_FC, 8'h01, pcp_pkg::RESP_OKAY);
    utx <= 1'b1;
    settle();
    chk(pin_out, 8'h01);
    utx <= 1'b0;
    settle();
    chk(pin_out, 8'h00);
    // input pins feed peripheral inputs
    wr(pcp_pkg::IDX_DIR, 8'h00, pcp_pkg::RESP_OKAY);
    ext_en <= 8'hFF;
    ext_val <= 8'h02;
    settle();
    chk({7'h00, urx}, 8'h01);
    sel <= pcp_pkg::PCP_SEL_SER_LO;
    ext_val <= 8'h04;
    settle();
    chk({6'h00, sdi, sck_i}, 8'h01);
    // two-wire pins driven low, then released and sensed high
    wr(pcp_pkg::IDX_FC, 8'h18, pcp_pkg::RESP_OKAY);
    wr(pcp_pkg::IDX_DIR, 8'h18, pcp_pkg::RESP_OKAY);
    ext_en <= 8'hE7;
    settle();
    chk(pin_oe & 8'h18, 8'h18);
    chk({6'h00, twc_i, twd_i}, 8'h00);
    {twc_o, twd_o} <= 2'h3;
    ext_en <= 8'hFF;
    ext_val <= 8'h18;
    settle();
    chk(pin_oe & 8'h18, 8'h00);
    chk({6'h00, twc_i, twd_i}, 8'h03);
    // uart transmit on pin one, receive from pin zero
    sel <= pcp_pkg::PCP_SEL_UART_B;
    utx <= 1'b1;
    wr(pcp_pkg::IDX_FC, 8'h2A, pcp_pkg::RESP_OKAY);
    wr(pcp_pkg::IDX_DIR, 8'h2A, pcp_pkg::RESP_OKAY);
    ext_en <= 8'hD5;
    ext_val <= 8'h00;
    settle();
    chk(pin_out & 8'h2A, 8'h02);
    chk({7'h00, urx}, 8'h00);
    // serial moved to pins three, four and five
    sel <= pcp_pkg::PCP_SEL_SER_HI;
    {sck_o, sdo_o, utx} <= 3'h6;
    ext_val <= 8'h10;
    settle();
    chk(pin_out & 8'h2A, 8'h28);
    chk(pin_oe & 8'h2A, 8'h2A);
    chk({6'h00, sdi, sck_i}, 8'h02);
    // second reset in mid-run: all pins back to input
    reset_n <= 1'b0;
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    chk(pin_oe, 8'h00);
    rd(pcp_pkg::IDX_FC, 8'h00, pcp_pkg::RESP_OKAY);
    rd(pcp_pkg::IDX_DIR, 8'h00, pcp_pkg::RESP_OKAY);
    conclude();
  end
endmodule

// >>> core/pcp_pkg.sv
// constants, carriers and state type of the port two pin control block
package pcp_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam int          ADDR_W     = 16;
  localparam int          IDX_W      = 14;
  localparam logic [13:0] IDX_LATCH  = 14'h0002;
  localparam logic [13:0] IDX_PRD    = 14'h000F;
  localparam logic [13:0] IDX_DIR    = 14'h0F1C;
  localparam logic [13:0] IDX_PU     = 14'h0F29;
  localparam logic [13:0] IDX_FC     = 14'h0F36;
  localparam logic [13:0] IDX_OT     = 14'h0F43;

  // ----------------------------------------------------------------------
  // reset values, implemented-bit masks and readback masks
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_LATCH  = 8'h00;
  localparam logic [7:0]  RST_DIR    = 8'h00;
  localparam logic [7:0]  RST_PU     = 8'h00;
  localparam logic [7:0]  RST_FC     = 8'h00;
  localparam logic [7:0]  RST_OT     = 8'h00;
  localparam logic [7:0]  MASK_FC    = 8'h3F;
  localparam logic [7:0]  MASK_OT    = 8'hE7;
  localparam logic [7:0]  MASK_PU    = 8'hE7;
  localparam logic [7:0]  MASK_GATED = 8'hE7;
  localparam logic [7:0]  MASK_LIVE  = 8'h18;

  // ----------------------------------------------------------------------
  // pin positions of secondary functions
  // ----------------------------------------------------------------------
  localparam int POS_UART_A  = 0;
  localparam int POS_UART_B  = 1;
  localparam int POS_SCLK_LO = 2;
  localparam int POS_SDA     = 3;
  localparam int POS_SCL     = 4;
  localparam int POS_SCLK_HI = 5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // which peripheral owns the shared pins, set by the selection logic
  typedef enum logic [1:0] {
    PCP_SEL_SER_LO = 2'b00,
    PCP_SEL_UART_A = 2'b01,
    PCP_SEL_UART_B = 2'b10,
    PCP_SEL_SER_HI = 2'b11
  } pcp_sel_t;

  typedef struct packed {
    logic        awvalid;
    logic [15:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [15:0] araddr;
    logic        rready;
  } pcp_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pcp_axi_rsp_t;

  typedef struct packed {
    logic        aw_have;
    logic [13:0] aw_idx;
    logic        w_have;
    logic [7:0]  w_data;
    logic        w_strb0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
    logic [7:0]  latch;
    logic [7:0]  dir;
    logic [7:0]  pu;
    logic [7:0]  fc;
    logic [7:0]  ot;
    logic [7:0]  pin_m;
    logic [7:0]  pin_s;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    logic [7:0]  pull;
    logic        sclk_in;
    logic        sdi;
    logic        urx;
    logic        twc;
    logic        twd;
  } pcp_state_t;

endpackage

// >>> core/pcp_port_two.sv
// port two pin control: direction, function routing, drivers, readback
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module pcp_port_two (
  input  wire logic                  clock,
  input  wire logic                  reset_n,
  input  wire pcp_pkg::pcp_axi_req_t axi_req,
  output      pcp_pkg::pcp_axi_rsp_t axi_rsp,
  input  wire logic [7:0]            pin_in,
  output      logic [7:0]            pin_out,
  output      logic [7:0]            pin_oe,
  output      logic [7:0]            pullup_on,
  input  wire pcp_pkg::pcp_sel_t     route_sel,
  input  wire logic                  serial_clock_out,
  input  wire logic                  serial_data_out,
  input  wire logic                  uart_transmit_line,
  input  wire logic                  twowire_clock_out,
  input  wire logic                  twowire_data_out,
  output      logic                  serial_clock_line,
  output      logic                  serial_data_in,
  output      logic                  uart_receive_line,
  output      logic                  twowire_clock_line,
  output      logic                  twowire_data_line
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  localparam pcp_pkg::pcp_state_t S_RST = '{
    awready : 1'h1,
    wready  : 1'h1,
    arready : 1'h1,
    urx     : 1'h1,
    latch   : pcp_pkg::RST_LATCH,
    dir     : pcp_pkg::RST_DIR,
    pu      : pcp_pkg::RST_PU,
    fc      : pcp_pkg::RST_FC,
    ot      : pcp_pkg::RST_OT,
    default : '0
  };

  pcp_pkg::pcp_state_t s_r;
  pcp_pkg::pcp_state_t s_nxt;
  logic [7:0]          periph_drv;
  logic [7:0]          twowire_od;
  logic [7:0]          readback;
  logic                drv_src;
  logic                open_drain;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    periph_drv = 8'h00;
    twowire_od = 8'h00;
    drv_src    = 1'h0;
    open_drain = 1'h0;
    readback   = s_r.pin_s & (~s_r.dir | s_r.ot | pcp_pkg::MASK_LIVE);
    s_nxt.pin_m = pin_in;
    s_nxt.pin_s = s_r.pin_m;

    // peripheral outputs onto their pins
    unique case (route_sel)
      pcp_pkg::PCP_SEL_SER_LO: begin
        periph_drv[pcp_pkg::POS_UART_A]  = serial_data_out;
        periph_drv[pcp_pkg::POS_SCLK_LO] = serial_clock_out;
      end
      pcp_pkg::PCP_SEL_UART_A: begin
        periph_drv[pcp_pkg::POS_UART_A] = uart_transmit_line;
      end
      pcp_pkg::PCP_SEL_UART_B: begin
        periph_drv[pcp_pkg::POS_UART_B] = uart_transmit_line;
      end
      pcp_pkg::PCP_SEL_SER_HI: begin
        periph_drv[pcp_pkg::POS_SDA]     = serial_data_out;
        periph_drv[pcp_pkg::POS_SCLK_HI] = serial_clock_out;
      end
    endcase
    if (route_sel != pcp_pkg::PCP_SEL_SER_HI) begin
      periph_drv[pcp_pkg::POS_SDA] = twowire_data_out;
      twowire_od[pcp_pkg::POS_SDA] = s_r.fc[pcp_pkg::POS_SDA];
    end
    periph_drv[pcp_pkg::POS_SCL] = twowire_clock_out;
    twowire_od[pcp_pkg::POS_SCL] = s_r.fc[pcp_pkg::POS_SCL];

    // per-pin driver and pull-up
    for (int i = 0; i < 8; i++) begin
      drv_src    = s_r.fc[i] ? periph_drv[i] : s_r.latch[i];
      open_drain = s_r.ot[i] | twowire_od[i];
      s_nxt.pin_out[i] = open_drain ? 1'h0 : drv_src;
      s_nxt.pin_oe[i]  = s_r.dir[i] & (~open_drain | ~drv_src);
      s_nxt.pull[i]    = s_r.pu[i] & (~s_r.dir[i] | s_r.ot[i]);
    end

    // pins in input mode to peripheral inputs; two-wire lines take their pins in any mode
    if (route_sel == pcp_pkg::PCP_SEL_SER_HI) begin
      s_nxt.sclk_in = ~s_r.dir[pcp_pkg::POS_SCLK_HI] &
                      s_r.pin_s[pcp_pkg::POS_SCLK_HI];
      s_nxt.sdi     = ~s_r.dir[pcp_pkg::POS_SCL] &
                      s_r.pin_s[pcp_pkg::POS_SCL];
    end else begin
      s_nxt.sclk_in = ~s_r.dir[pcp_pkg::POS_SCLK_LO] &
                      s_r.pin_s[pcp_pkg::POS_SCLK_LO];
      s_nxt.sdi     = ~s_r.dir[pcp_pkg::POS_UART_B] &
                      s_r.pin_s[pcp_pkg::POS_UART_B];
    end
    if (route_sel == pcp_pkg::PCP_SEL_UART_B) begin
      s_nxt.urx = s_r.dir[pcp_pkg::POS_UART_A] |
                  s_r.pin_s[pcp_pkg::POS_UART_A];
    end else begin
      s_nxt.urx = s_r.dir[pcp_pkg::POS_UART_B] |
                  s_r.pin_s[pcp_pkg::POS_UART_B];
    end
    s_nxt.twc = s_r.pin_s[pcp_pkg::POS_SCL];
    s_nxt.twd = s_r.pin_s[pcp_pkg::POS_SDA];

    // write address and data, taken in either order
    if (axi_req.awvalid && s_r.awready) begin
      s_nxt.aw_have = 1'h1;
      s_nxt.aw_idx  = axi_req.awaddr[15:2];
    end
    if (axi_req.wvalid && s_r.wready) begin
      s_nxt.w_have  = 1'h1;
      s_nxt.w_data  = axi_req.wdata[7:0];
      s_nxt.w_strb0 = axi_req.wstrb[0];
    end
    if (s_r.bvalid && axi_req.bready) begin
      s_nxt.bvalid = 1'h0;
    end
    if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
      s_nxt.aw_have = 1'h0;
      s_nxt.w_have  = 1'h0;
      s_nxt.bvalid  = 1'h1;
      s_nxt.bresp   = pcp_pkg::RESP_OKAY;
      case (s_r.aw_idx)
        pcp_pkg::IDX_LATCH: begin
          if (s_r.w_strb0) s_nxt.latch = s_r.w_data;
        end
        pcp_pkg::IDX_DIR: begin
          if (s_r.w_strb0) s_nxt.dir = s_r.w_data;
        end
        pcp_pkg::IDX_PU: begin
          if (s_r.w_strb0) s_nxt.pu = s_r.w_data & pcp_pkg::MASK_PU;
        end
        pcp_pkg::IDX_FC: begin
          if (s_r.w_strb0) s_nxt.fc = s_r.w_data & pcp_pkg::MASK_FC;
        end
        pcp_pkg::IDX_OT: begin
          if (s_r.w_strb0) s_nxt.ot = s_r.w_data & pcp_pkg::MASK_OT;
        end
        pcp_pkg::IDX_PRD: begin
          s_nxt.bresp = pcp_pkg::RESP_OKAY;
        end
        default: begin
          s_nxt.bresp = pcp_pkg::RESP_SLVERR;
        end
      endcase
    end
    s_nxt.awready = ~s_nxt.aw_have;
    s_nxt.wready  = ~s_nxt.w_have;

    // read channel
    if (axi_req.arvalid && s_r.arready) begin
      s_nxt.arready = 1'h0;
      s_nxt.rvalid  = 1'h1;
      s_nxt.rresp   = pcp_pkg::RESP_OKAY;
      case (axi_req.araddr[15:2])
        pcp_pkg::IDX_LATCH: s_nxt.rdata = s_r.latch;
        pcp_pkg::IDX_PRD:   s_nxt.rdata = readback;
        pcp_pkg::IDX_DIR:   s_nxt.rdata = s_r.dir;
        pcp_pkg::IDX_PU:    s_nxt.rdata = s_r.pu;
        pcp_pkg::IDX_FC:    s_nxt.rdata = s_r.fc;
        pcp_pkg::IDX_OT:    s_nxt.rdata = s_r.ot;
        default: begin
          s_nxt.rdata = 8'h00;
          s_nxt.rresp = pcp_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_r.rvalid && axi_req.rready) begin
      s_nxt.rvalid  = 1'h0;
      s_nxt.arready = 1'h1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= S_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign axi_rsp.awready    = s_r.awready;
  assign axi_rsp.wready     = s_r.wready;
  assign axi_rsp.bvalid     = s_r.bvalid;
  assign axi_rsp.bresp      = s_r.bresp;
  assign axi_rsp.arready    = s_r.arready;
  assign axi_rsp.rvalid     = s_r.rvalid;
  assign axi_rsp.rdata      = {24'h000000, s_r.rdata};
  assign axi_rsp.rresp      = s_r.rresp;
  assign pin_out            = s_r.pin_out;
  assign pin_oe             = s_r.pin_oe;
  assign pullup_on          = s_r.pull;
  assign serial_clock_line  = s_r.sclk_in;
  assign serial_data_in     = s_r.sdi;
  assign uart_receive_line  = s_r.urx;
  assign twowire_clock_line = s_r.twc;
  assign twowire_data_line  = s_r.twd;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_dir_input:
    assert property ((s_r.pin_oe & ~$past(s_r.dir)) == 8'h00)
    else $error("input-mode pin is driven");

  a_latch_route:
    assert property (((s_r.pin_out ^ $past(s_r.latch)) &
                      $past(s_r.dir & ~s_r.fc & ~s_r.ot)) == 8'h00)
    else $error("push-pull pin does not follow latch");

  a_sclk_in:
    assert property ($past(!s_r.dir[pcp_pkg::POS_SCLK_LO] &&
                     route_sel == pcp_pkg::PCP_SEL_SER_LO) |->
                     s_r.sclk_in == $past(s_r.pin_s[pcp_pkg::POS_SCLK_LO]))
    else $error("serial clock input not routed");

  a_scl_drive:
    assert property ($past(s_r.fc[pcp_pkg::POS_SCL] &&
                     s_r.dir[pcp_pkg::POS_SCL]) |->
                     s_r.pin_oe[pcp_pkg::POS_SCL] == !$past(twowire_clock_out)
                     && !s_r.pin_out[pcp_pkg::POS_SCL])
    else $error("two-wire clock not open drain");

  a_scl_sense:
    assert property (s_r.twc == $past(s_r.pin_s[pcp_pkg::POS_SCL]))
    else $error("two-wire clock not sensed");

  a_ot_holes:
    assert property ((s_r.ot & pcp_pkg::MASK_LIVE) == 8'h00)
    else $error("output type bits 3 or 4 set");

  a_pull_gate:
    assert property ((s_r.pull & $past(s_r.dir & ~s_r.ot)) == 8'h00)
    else $error("pull-up on push-pull output");

  a_rd_live:
    assert property ((axi_req.arvalid && s_r.arready &&
                     axi_req.araddr[15:2] == pcp_pkg::IDX_PRD) |=>
                     ((s_r.rdata ^ $past(s_r.pin_s)) &
                      $past(~s_r.dir)) == 8'h00)
    else $error("input pin readback wrong");

  a_rd_gated:
    assert property ((axi_req.arvalid && s_r.arready &&
                     axi_req.araddr[15:2] == pcp_pkg::IDX_PRD) |=>
                     (s_r.rdata & $past(s_r.dir & ~s_r.ot) &
                      pcp_pkg::MASK_GATED) == 8'h00)
    else $error("push-pull readback not zero");

  a_od_release:
    assert property ((s_r.pin_out & $past(s_r.ot)) == 8'h00)
    else $error("open drain pin driven high");

  a_rd_always:
    assert property ((axi_req.arvalid && s_r.arready &&
                     axi_req.araddr[15:2] == pcp_pkg::IDX_PRD) |=>
                     ((s_r.rdata ^ $past(s_r.pin_s)) &
                      pcp_pkg::MASK_LIVE) == 8'h00)
    else $error("bits 3 or 4 readback not live");

  a_sdo_hi:
    assert property ($past(route_sel == pcp_pkg::PCP_SEL_SER_HI &&
                     s_r.fc[pcp_pkg::POS_SDA]) |->
                     s_r.pin_out[pcp_pkg::POS_SDA] == $past(serial_data_out))
    else $error("serial data out not on pin three");

  a_uart_b_tx:
    assert property ($past(route_sel == pcp_pkg::PCP_SEL_UART_B &&
                     s_r.fc[pcp_pkg::POS_UART_B] &&
                     !s_r.ot[pcp_pkg::POS_UART_B]) |->
                     s_r.pin_out[pcp_pkg::POS_UART_B] ==
                     $past(uart_transmit_line))
    else $error("uart transmit not on pin one");

  a_urx_route:
    assert property ($past(route_sel == pcp_pkg::PCP_SEL_UART_B &&
                     !s_r.dir[pcp_pkg::POS_UART_A]) |->
                     s_r.urx == $past(s_r.pin_s[pcp_pkg::POS_UART_A]))
    else $error("uart receive not routed from pin zero");

endmodule
